// ===== logic/synth_control_register_bank.sv
// Control register bank of the fractional-N synthesizer behind its serial port.
//
// Overview of operation
// - Select bit one: enable follows pin.
// - Select bit zero: pin ignored, register used.
// - Register enable bit powers chip up/down.
// - Seven keep-on bits hold blocks powered.
// - Sync sleep: tri-state detector at ref fall.
// - Reference divider: 14 bits, one bypasses.
// - Integer word used always; fractional 36 minimum.
// - Integer mode ratio spans 32 to 65535.
// - Fine word 24 bits, fractional mode only.
// - Seed is modulator starting state.
// - Keying enabled: seed is first frequency.
// - Type field: two is B, three A.
// - Core reset-bar low holds core reset.
// - Buffer reset-bar low holds buffers reset.
// - Ignore bit drops modulator output.
// - Auto-reload: fine write reloads seed.
// - Keying enable uses data pin as key.
// - Clock select: one reference, zero VCO.
// - Invert bit inverts modulator clock.
// - Four-bit slip correction magnitude.
// - Thirty-two clock frame, MSB first.
// - Divider writes take effect immediately.
// - Power down: writes work, reads silent.
// - Soft reset restores all defaults.
`timescale 1ns/1ps
`default_nettype none
module synth_control_register_bank
   import synth_ctrl_pkg::*;
#(
   // Identification word returned on reads of address zero; the value is arbitrary.
   parameter logic [DATA_W-1:0] CHIP_ID_VALUE = 24'h5a0001
) (
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Serial port and chip pins.
   input wire logic sck,
   input wire logic sen,
   input wire logic sdi,
   input wire logic ce_pin,
   input wire logic ref_clk,
   output logic sdo,
   output logic sdo_oe,
   // Power control.
   output logic chip_enable,
   output logic [PWR_KEEP_W-1:0] block_on,
   output logic pfd_tristate,
   output logic sleep_active,
   // Dividers.
   output logic [13:0] ref_div_ratio,
   output logic ref_div_bypass,
   output logic ref_div_illegal,
   output logic [15:0] vco_int_word,
   output logic [23:0] vco_fine_word,
   output logic int_word_invalid,
   output logic fractional_mode,
   // Modulator.
   output logic [23:0] seed_word,
   output logic seed_load,
   output logic seed_is_f1,
   output logic fsk_active,
   output logic fsk_key,
   output logic mod_type_b,
   output logic mod_type_a,
   output logic mod_core_reset,
   output logic mod_buffer_reset,
   output logic mod_output_ignore,
   output logic mod_clk_from_ref,
   output logic mod_clk_invert,
   output logic [3:0] csp_magnitude
);

   logic [PIN_COUNT-1:0] pins_s;
   logic sck_prev_reg, ref_prev_reg, sck_rise, ref_fall;
   logic wr_pulse, eng_sdo, eng_active, soft_reset;
   logic [ADDR_W-1:0] eng_addr;
   logic [DATA_W-1:0] eng_wr_data, rd_data;
   logic [9:0] power_reg, power_next;
   logic [13:0] refdiv_reg, refdiv_next;
   logic [15:0] int_reg, int_next;
   logic [23:0] fine_reg, fine_next;
   logic [23:0] seed_reg, seed_next;
   logic [23:0] cfg_reg, cfg_next;
   logic src_enable, chip_enable_next;
   sleep_state_type sleep_reg, sleep_next;

   // Fractional operation needs both resets released and the output in use.
   function automatic logic is_frac(input logic [23:0] cfg);
      is_frac = cfg[CFG_IGNORE:CFG_CORE_RSTB] == FRAC_MODE_CODE;
   endfunction

   // The lower bound on the integer word depends on the mode.
   function automatic logic int_bad(input logic [15:0] word, input logic [23:0] cfg);
      int_bad = is_frac(cfg) ? (word < INT_MIN_FRAC) : (word < INT_MIN_INT);
   endfunction

   // A write is decoded only when the last data bit of a frame arrives for this address.
   function automatic logic hit(input logic [ADDR_W-1:0] a);
      hit = wr_pulse && eng_addr == a;
   endfunction

   pin_sync u_pin_sync (
      .clk(clk),
      .sys_rst(sys_rst),
      .pins_raw({ref_clk, ce_pin, sdi, sen, sck}),
      .pins_sync(pins_s)
   );

   serial_frame_engine u_frame (
      .clk(clk),
      .sys_rst(sys_rst),
      .sen(pins_s[PIN_SEN]),
      .sck_rise(sck_rise),
      .sdi(pins_s[PIN_SDI]),
      .rd_data(rd_data),
      .wr_pulse(wr_pulse),
      .addr(eng_addr),
      .wr_data(eng_wr_data),
      .sdo_bit(eng_sdo),
      .sdo_active(eng_active)
   );

   // Edge detection on the filtered pins; the serial clock must stay well below clk.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sck_prev_reg <= 1'b0;
         ref_prev_reg <= 1'b0;
      end else begin
         sck_prev_reg <= pins_s[PIN_SCK];
         ref_prev_reg <= pins_s[PIN_REF];
      end
   end

   assign sck_rise = pins_s[PIN_SCK] && !sck_prev_reg;
   assign ref_fall = ref_prev_reg && !pins_s[PIN_REF];
   assign soft_reset = hit(ADDR_STROBE) && eng_wr_data[STROBE_SOFT_RESET];

   // Register read mux; address zero reads the identification word.
   always_comb begin
      case (eng_addr)
         ADDR_STROBE: rd_data = CHIP_ID_VALUE;
         ADDR_POWER: rd_data = {14'h0000, power_reg};
         ADDR_REFDIV: rd_data = {10'h000, refdiv_reg};
         ADDR_INT: rd_data = {8'h00, int_reg};
         ADDR_FINE: rd_data = fine_reg;
         ADDR_SEED: rd_data = seed_reg;
         ADDR_CFG: rd_data = cfg_reg;
         default: rd_data = 24'h000000;
      endcase
   end

   // Next register values; writes are accepted even during power down.
   // Both resets load the defaults here, so every flop fed from a next value resets with it.
   always_comb begin
      power_next = power_reg;
      refdiv_next = refdiv_reg;
      int_next = int_reg;
      fine_next = fine_reg;
      seed_next = seed_reg;
      cfg_next = cfg_reg;
      if (sys_rst || soft_reset) begin
         power_next = POWER_RESET;
         refdiv_next = REFDIV_RESET;
         int_next = INT_RESET;
         fine_next = FINE_RESET;
         seed_next = SEED_RESET;
         cfg_next = CFG_RESET;
      end else begin
         if (hit(ADDR_POWER)) power_next = eng_wr_data[9:0];
         if (hit(ADDR_REFDIV)) refdiv_next = eng_wr_data[13:0];
         if (hit(ADDR_INT)) int_next = eng_wr_data[15:0];
         if (hit(ADDR_FINE)) fine_next = eng_wr_data;
         if (hit(ADDR_SEED)) seed_next = eng_wr_data;
         // Reserved bits are never taken from the bus.
         if (hit(ADDR_CFG)) begin
            cfg_next = (cfg_reg & ~CFG_WRITE_MASK) | (eng_wr_data & CFG_WRITE_MASK);
         end
      end
   end

   // Register storage; the defaults arrive through the next values during reset.
   always_ff @(posedge clk) begin
      power_reg <= power_next;
      refdiv_reg <= refdiv_next;
      int_reg <= int_next;
      fine_reg <= fine_next;
      seed_reg <= seed_next;
      cfg_reg <= cfg_next;
   end

   // Synchronised sleep waits for a reference falling edge; clearing the bit wakes.
   always_comb begin
      sleep_next = sleep_reg;
      case (sleep_reg)
         SLEEP_IDLE: if (power_next[PWR_SYNC_SLEEP]) sleep_next = SLEEP_WAIT_EDGE;
         SLEEP_WAIT_EDGE: begin
            if (!power_next[PWR_SYNC_SLEEP]) sleep_next = SLEEP_IDLE;
            else if (ref_fall) sleep_next = SLEEP_ASLEEP;
         end
         SLEEP_ASLEEP: if (!power_next[PWR_SYNC_SLEEP]) sleep_next = SLEEP_IDLE;
         default: sleep_next = SLEEP_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (sys_rst) sleep_reg <= SLEEP_IDLE;
      else sleep_reg <= sleep_next;
   end

   // Enable source: the pin or the register bit, then gated by sleep.
   assign src_enable = power_next[PWR_PIN_SEL] ? pins_s[PIN_CE] : power_next[PWR_REG_EN];
   assign chip_enable_next = src_enable && sleep_next != SLEEP_ASLEEP;

   // Power outputs; a kept block stays on whatever caused the power down.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         chip_enable <= 1'b0;
         block_on <= '0;
         pfd_tristate <= 1'b0;
         sleep_active <= 1'b0;
      end else begin
         chip_enable <= chip_enable_next;
         for (int i = 0; i < PWR_KEEP_W; i++) begin
            block_on[i] <= chip_enable_next || power_next[PWR_KEEP_LO + i];
         end
         pfd_tristate <= sleep_next == SLEEP_ASLEEP;
         sleep_active <= sleep_next == SLEEP_ASLEEP;
      end
   end

   // Read data leave only while powered; the pad is released otherwise.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         sdo <= 1'b0;
         sdo_oe <= 1'b0;
      end else begin
         sdo <= eng_sdo && chip_enable;
         sdo_oe <= eng_active && chip_enable;
      end
   end

   // Divider outputs follow the written values with no double buffering.
   always_ff @(posedge clk) begin
      ref_div_ratio <= refdiv_next;
      ref_div_bypass <= refdiv_next == REFDIV_BYPASS;
      ref_div_illegal <= refdiv_next == 14'h0000;
      vco_int_word <= int_next;
      vco_fine_word <= is_frac(cfg_next) ? fine_next : 24'h000000;
      int_word_invalid <= int_bad(int_next, cfg_next);
      fractional_mode <= is_frac(cfg_next);
   end

   // Modulator controls and the seed reload on fine-word writes.
   always_ff @(posedge clk) begin
      seed_word <= seed_next;
      seed_load <= !sys_rst && hit(ADDR_FINE) && !soft_reset && cfg_reg[CFG_AUTOSEED];
      seed_is_f1 <= cfg_next[CFG_FSK];
      fsk_active <= cfg_next[CFG_FSK];
      // The data pin keys only between frames, so register traffic cannot key.
      fsk_key <= cfg_next[CFG_FSK] && !pins_s[PIN_SEN] && pins_s[PIN_SDI];
      mod_type_b <= cfg_next[CFG_ORDER_LO +: 2] == ORDER_TYPE_B;
      mod_type_a <= cfg_next[CFG_ORDER_LO +: 2] == ORDER_TYPE_A;
      mod_core_reset <= !cfg_next[CFG_CORE_RSTB];
      mod_buffer_reset <= !cfg_next[CFG_BUF_RSTB];
      mod_output_ignore <= cfg_next[CFG_IGNORE];
      mod_clk_from_ref <= cfg_next[CFG_CLK_REF];
      mod_clk_invert <= cfg_next[CFG_CLK_INV];
      csp_magnitude <= cfg_next[CFG_CSP_LO +: 4];
   end

   // Checks on the behaviour above.
   default clocking cb @(posedge clk); endclocking
   default disable iff (sys_rst);

   sequence fine_write_s;
      hit(ADDR_FINE) && !soft_reset;
   endsequence

   sequence sleep_trigger_s;
      sleep_reg == SLEEP_WAIT_EDGE && ref_fall && power_next[PWR_SYNC_SLEEP];
   endsequence

   pin_power_down_a: assert property (
      power_next[PWR_PIN_SEL] && !pins_s[PIN_CE] |=> !chip_enable)
      else $error("pin low did not power down");
   reg_enable_a: assert property (
      !power_next[PWR_PIN_SEL] && power_next[PWR_REG_EN] && sleep_next != SLEEP_ASLEEP |=> chip_enable)
      else $error("register enable ignored");
   reg_disable_a: assert property (
      !power_reg[PWR_PIN_SEL] && !power_reg[PWR_REG_EN] && $stable(power_reg) |-> !chip_enable)
      else $error("register disable ignored");
   keep_on_a: assert property (
      !chip_enable |-> block_on == power_reg[PWR_KEEP_LO +: PWR_KEEP_W])
      else $error("keep-on bits not honoured");
   sleep_edge_a: assert property (
      sleep_trigger_s |=> pfd_tristate && sleep_active && !chip_enable)
      else $error("sleep not entered at reference fall");
   refdiv_flags_a: assert property (
      ref_div_bypass == (ref_div_ratio == REFDIV_BYPASS) && ref_div_illegal == (ref_div_ratio == 0))
      else $error("reference divider flags wrong");
   int_range_a: assert property (
      int_word_invalid == (fractional_mode ? vco_int_word < INT_MIN_FRAC : vco_int_word < INT_MIN_INT))
      else $error("integer range flag wrong");
   fine_mode_a: assert property (
      !fractional_mode |-> vco_fine_word == 24'h000000)
      else $error("fine word used outside fractional mode");
   int_write_a: assert property (
      hit(ADDR_INT) && !soft_reset |=> vco_int_word == eng_wr_data[15:0])
      else $error("integer word not applied at once");
   autoseed_a: assert property (
      fine_write_s ##0 cfg_reg[CFG_AUTOSEED] |=> seed_load && seed_word == seed_reg)
      else $error("seed not reloaded on fine write");
   order_a: assert property (
      mod_type_b == (cfg_reg[CFG_ORDER_LO +: 2] == ORDER_TYPE_B) && !(mod_type_a && mod_type_b))
      else $error("modulator type decode wrong");
   read_silent_a: assert property (
      !chip_enable |=> !sdo_oe)
      else $error("read data driven in power down");
   soft_reset_a: assert property (
      soft_reset |=> cfg_reg == CFG_RESET && power_reg == POWER_RESET && int_reg == INT_RESET)
      else $error("soft reset left registers changed");
   reserved_a: assert property (
      (cfg_reg & ~CFG_WRITE_MASK) == (CFG_RESET & ~CFG_WRITE_MASK) && !cfg_reg[14])
      else $error("reserved configuration bits changed");

endmodule
`default_nettype wire

// ===== pkg/synth_ctrl_pkg.sv
// Shared constants and types for the synthesizer control register bank.
package synth_ctrl_pkg;

   // Serial frame geometry.
   localparam int ADDR_W = 6;
   localparam int DATA_W = 24;
   localparam int PIN_COUNT = 5;
   // Rising-edge counts inside a frame, counted from zero before the first edge.
   localparam logic [5:0] CNT_ADDR_LAST = 6'h06;
   localparam logic [5:0] CNT_DATA_FIRST = 6'h07;
   localparam logic [5:0] CNT_DATA_LAST = 6'h1e;
   localparam logic [5:0] CNT_FRAME_END = 6'h1f;

   // Pin positions inside the synchronised pin vector.
   localparam int PIN_SCK = 0;
   localparam int PIN_SEN = 1;
   localparam int PIN_SDI = 2;
   localparam int PIN_CE = 3;
   localparam int PIN_REF = 4;

   // Register addresses.
   localparam logic [5:0] ADDR_STROBE = 6'h00;
   localparam logic [5:0] ADDR_POWER = 6'h01;
   localparam logic [5:0] ADDR_REFDIV = 6'h02;
   localparam logic [5:0] ADDR_INT = 6'h03;
   localparam logic [5:0] ADDR_FINE = 6'h04;
   localparam logic [5:0] ADDR_SEED = 6'h05;
   localparam logic [5:0] ADDR_CFG = 6'h06;

   // Reset values.
   localparam logic [9:0] POWER_RESET = 10'h001;
   localparam logic [13:0] REFDIV_RESET = 14'h0001;
   localparam logic [15:0] INT_RESET = 16'h00c8;
   localparam logic [23:0] FINE_RESET = 24'h000000;
   localparam logic [23:0] SEED_RESET = 24'h000000;
   localparam logic [23:0] CFG_RESET = 24'h842e87;
   // Bits of the modulator configuration that software may change.
   localparam logic [23:0] CFG_WRITE_MASK = 24'hfebf00;

   // Power control fields.
   localparam int PWR_PIN_SEL = 0;
   localparam int PWR_REG_EN = 1;
   localparam int PWR_KEEP_LO = 2;
   localparam int PWR_KEEP_W = 7;
   localparam int PWR_SYNC_SLEEP = 9;
   localparam int STROBE_SOFT_RESET = 0;

   // Modulator configuration fields.
   localparam int CFG_ORDER_LO = 8;
   localparam int CFG_CORE_RSTB = 10;
   localparam int CFG_BUF_RSTB = 11;
   localparam int CFG_IGNORE = 12;
   localparam int CFG_AUTOSEED = 13;
   localparam int CFG_FSK = 15;
   localparam int CFG_CLK_REF = 17;
   localparam int CFG_CLK_INV = 18;
   localparam int CFG_CSP_LO = 20;
   localparam logic [1:0] ORDER_TYPE_B = 2'h2;
   localparam logic [1:0] ORDER_TYPE_A = 2'h3;
   localparam logic [2:0] FRAC_MODE_CODE = 3'h3;

   // Divider limits.
   localparam logic [13:0] REFDIV_BYPASS = 14'h0001;
   localparam logic [15:0] INT_MIN_FRAC = 16'h0024;
   localparam logic [15:0] INT_MIN_INT = 16'h0020;

   // Synchronised sleep sequence.
   typedef enum logic [1:0] {SLEEP_IDLE, SLEEP_WAIT_EDGE, SLEEP_ASLEEP} sleep_state_type;

endpackage

// ===== logic/pin_sync.sv
// Three-stage synchroniser with agreement filter for the external pins.
`timescale 1ns/1ps
`default_nettype none
module pin_sync
   import synth_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Raw pins and their filtered levels.
   input wire logic [PIN_COUNT-1:0] pins_raw,
   output logic [PIN_COUNT-1:0] pins_sync
);

   logic [PIN_COUNT-1:0] stage1_reg;
   logic [PIN_COUNT-1:0] stage2_reg;
   logic [PIN_COUNT-1:0] stage3_reg;

   // The first stage feeds only the second, so metastability never reaches logic.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         stage1_reg <= '0;
         stage2_reg <= '0;
         stage3_reg <= '0;
      end else begin
         stage1_reg <= pins_raw;
         stage2_reg <= stage1_reg;
         stage3_reg <= stage2_reg;
      end
   end

   // A level change is accepted only once the second and third stages agree.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         pins_sync <= '0;
      end else begin
         for (int i = 0; i < PIN_COUNT; i++) begin
            if (stage2_reg[i] == stage3_reg[i]) begin
               pins_sync[i] <= stage3_reg[i];
            end
         end
      end
   end

endmodule
`default_nettype wire

// ===== logic/serial_frame_engine.sv
// Serial frame decoder: direction bit, address, data in and read data out.
`timescale 1ns/1ps
`default_nettype none
module serial_frame_engine
   import synth_ctrl_pkg::*;
(
   // Clock and reset.
   input wire logic clk,
   input wire logic sys_rst,
   // Synchronised serial pins.
   input wire logic sen,
   input wire logic sck_rise,
   input wire logic sdi,
   // Read data for the addressed register.
   input wire logic [DATA_W-1:0] rd_data,
   // Decoded write.
   output logic wr_pulse,
   output logic [ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] wr_data,
   // Serial read data.
   output logic sdo_bit,
   output logic sdo_active
);

   logic [5:0] cnt_reg;
   logic rw_reg;
   logic [DATA_W-1:0] shift_reg;

   // Bits arrive most significant first; edges past the frame end are ignored.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         cnt_reg <= 6'h00;
         rw_reg <= 1'b0;
         addr <= '0;
         wr_data <= '0;
      end else if (!sen) begin
         cnt_reg <= 6'h00;
      end else if (sck_rise && cnt_reg <= CNT_FRAME_END) begin
         cnt_reg <= cnt_reg + 6'h01;
         if (cnt_reg == 6'h00) begin
            rw_reg <= sdi;
         end else if (cnt_reg <= CNT_ADDR_LAST) begin
            addr <= {addr[ADDR_W-2:0], sdi};
         end else if (cnt_reg <= CNT_DATA_LAST) begin
            wr_data <= {wr_data[DATA_W-2:0], sdi};
         end
      end
   end

   // A write commits on the last data bit, in the same cycle the word is complete.
   always_ff @(posedge clk) begin
      if (sys_rst) begin
         wr_pulse <= 1'b0;
      end else begin
         wr_pulse <= sen && sck_rise && cnt_reg == CNT_DATA_LAST && !rw_reg;
      end
   end

   // Read data leaves on the rising edges after the address and stops at the frame end.
   always_ff @(posedge clk) begin
      if (sys_rst || !sen) begin
         sdo_bit <= 1'b0;
         sdo_active <= 1'b0;
         shift_reg <= '0;
      end else if (sck_rise) begin
         if (cnt_reg == CNT_DATA_FIRST && rw_reg) begin
            sdo_active <= 1'b1;
            sdo_bit <= rd_data[DATA_W-1];
            shift_reg <= {rd_data[DATA_W-2:0], 1'b0};
         end else if (cnt_reg == CNT_FRAME_END) begin
            sdo_active <= 1'b0;
            sdo_bit <= 1'b0;
         end else if (sdo_active) begin
            sdo_bit <= shift_reg[DATA_W-1];
            shift_reg <= {shift_reg[DATA_W-2:0], 1'b0};
         end
      end
   end

endmodule
`default_nettype wire

// ===== testbench/host_serial_model.sv
// Host model that shifts whole 32-clock frames through the serial port.
`timescale 1ns/1ps
`default_nettype none
module host_serial_model (
   // Clock.
   input wire logic clk,
   // Serial port.
   input wire logic sdo,
   input wire logic sdo_oe,
   output var logic sck,
   output var logic sen,
   output var logic sdi
);
   // The serial clock stands low between frames.
   initial begin
      sck = 1'b0;
      sen = 1'b0;
      sdi = 1'b0;
   end

   // Half periods of eight cycles keep each phase well above the pin filter.
   task automatic xfer(input logic rw, input logic [5:0] a, input logic [23:0] d,
      output logic [23:0] q);
      logic [30:0] f;
      f = {rw, a, d};
      q = 24'h0;
      sen <= 1'b1;
      for (int i = 0; i < 32; i++) begin
         sck <= 1'b0;
         sdi <= (i < 31) ? f[30-i] : ~f[0];
         repeat (8) @(posedge clk);
         // A released pad is modelled as pulled up, so a silent read returns all ones.
         if (i >= 8) q[31-i] = sdo_oe ? sdo : 1'b1;
         sck <= 1'b1;
         repeat (8) @(posedge clk);
      end
      sck <= 1'b0;
      repeat (8) @(posedge clk);
      sen <= 1'b0;
      repeat (8) @(posedge clk);
   endtask
endmodule
`default_nettype wire

// ===== testbench/tb_synth_control_register_bank.sv
// Self-checking bench for the synthesizer control register bank.
`timescale 1ns/1ps
`default_nettype none
module tb_synth_control_register_bank
   import synth_ctrl_pkg::*;
;
   localparam logic [23:0] ID = 24'h3c0aa5; // Arbitrary identification value.
   logic clk, sys_rst, ce_pin, sck, sen, sdi, sdo, sdo_oe, chip_enable, pfd_tristate;
   logic ref_clk = 1'b0;
   logic sleep_active, ref_div_bypass, ref_div_illegal, int_word_invalid, fractional_mode;
   logic seed_load, seed_is_f1, fsk_active, fsk_key, mod_type_b, mod_type_a;
   logic mod_core_reset, mod_buffer_reset, mod_output_ignore, mod_clk_from_ref, mod_clk_invert;
   logic [6:0] block_on;
   logic [13:0] ref_div_ratio;
   logic [15:0] vco_int_word;
   logic [23:0] vco_fine_word, seed_word, d, m [7];
   logic [23:0] n_load = 24'h0;
   logic [23:0] n_exp = 24'h0;
   logic [3:0] csp_magnitude;
   logic [31:0] rnd = 32'h5073;
   logic [5:0] a;
   int cyc = 0;
   int miscompares = 0;
   int check_count = 0;

   synth_control_register_bank #(.CHIP_ID_VALUE(ID)) uut (.clk, .sys_rst, .sck, .sen, .sdi,
      .ce_pin, .ref_clk, .sdo, .sdo_oe, .chip_enable, .block_on, .pfd_tristate, .sleep_active,
      .ref_div_ratio, .ref_div_bypass, .ref_div_illegal, .vco_int_word, .vco_fine_word,
      .int_word_invalid, .fractional_mode, .seed_word, .seed_load, .seed_is_f1, .fsk_active,
      .fsk_key, .mod_type_b, .mod_type_a, .mod_core_reset, .mod_buffer_reset,
      .mod_output_ignore, .mod_clk_from_ref, .mod_clk_invert, .csp_magnitude);
   host_serial_model host (.clk, .sdo, .sdo_oe, .sck, .sen, .sdi);

   // Free-running system clock.
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end

   // Slow reference clock, seed load counting and the hang limit.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      ref_clk <= cyc[3];
      if (seed_load === 1'b1) n_load <= n_load + 24'h1;
      if (cyc == 90000) begin
         miscompares++;
         tally_and_finish();
      end
   end

   function automatic logic [31:0] xs(input logic [31:0] v);
      v = v ^ (v << 13);
      v = v ^ (v >> 17);
      v = v ^ (v << 5);
      return v;
   endfunction

   task automatic chk(input string n, input logic [23:0] s, input logic [23:0] e);
      check_count++;
      if (s !== e) begin
         miscompares++;
         $display("CHECK FAILED %s expected %h seen %h", n, e, s);
      end
   endtask

   task automatic mrst();
      m = '{ID, 24'(POWER_RESET), 24'(REFDIV_RESET), 24'(INT_RESET), FINE_RESET, SEED_RESET,
         CFG_RESET};
   endtask

   // Every divider and modulator output other than the seed load against the model.
   task automatic outs();
      logic [23:0] c;
      c = m[6];
      chk("int", vco_int_word, m[3]);
      chk("fine", vco_fine_word, (c[12:10] == 3'h3) ? m[4] : 24'h0);
      chk("rdiv", {ref_div_illegal, ref_div_bypass, ref_div_ratio},
         {m[2] == 0, m[2] == 1, m[2][13:0]});
      chk("seed", seed_word, m[5]);
      chk("cfg", {csp_magnitude, mod_clk_invert, mod_clk_from_ref, fsk_active, seed_is_f1,
         mod_output_ignore, mod_buffer_reset, mod_core_reset, mod_type_a, mod_type_b,
         fractional_mode, int_word_invalid, fsk_key}, {c[23:20], c[18], c[17], c[15], c[15],
         c[12], !c[11], !c[10], c[9:8] == 2'h3, c[9:8] == 2'h2, c[12:10] == 3'h3,
         (c[12:10] == 3'h3) ? m[3] < 36 : m[3] < 32, c[15] & sdi});
   endtask

   task automatic rd(input logic [5:0] a, input logic [23:0] e);
      logic [23:0] q;
      host.xfer(1'b1, a, 24'h0, q);
      chk("read", q, e);
      chk("sdo_oe", 24'(sdo_oe), 24'h0);
   endtask

   // A fine word write with auto reload set must pulse the seed load once.
   task automatic wr(input logic [5:0] a, input logic [23:0] d);
      logic [23:0] q;
      if (a == 6'h4 && m[6][13]) n_exp = n_exp + 24'h1;
      host.xfer(1'b0, a, d, q);
      case (a)
         6'h0: if (d[0]) mrst();
         6'h1: m[1] = 24'(d[9:0]);
         6'h2: m[2] = 24'(d[13:0]);
         6'h3: m[3] = 24'(d[15:0]);
         6'h4, 6'h5: m[a] = d;
         6'h6: m[6] = (m[6] & ~CFG_WRITE_MASK) | (d & CFG_WRITE_MASK);
         default: ;
      endcase
      outs();
      chk("load", n_load, n_exp);
   endtask

   task automatic chkall();
      outs();
      for (int i = 0; i < 7; i++) rd(6'(i), m[i]);
      rd(6'h3f, 24'h0);
   endtask

   task automatic pw(input logic ce, input logic [6:0] b);
      chk("power", {chip_enable, block_on}, {ce, b});
   endtask

   task automatic tally_and_finish();
      if (miscompares == 0 && check_count > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence.
   initial begin
      sys_rst = 1'b1;
      ce_pin = 1'b1;
      mrst();
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (8) @(posedge clk);
      chkall();
      wr(6'h3f, 24'hffffff);
      wr(6'h6, CFG_RESET);
      wr(6'h4, 24'h123456);
      repeat (24) begin
         rnd = xs(rnd);
         a = 6'(2 + rnd[31:24] % 5);
         d = rnd[23:0];
         if (a == 6'h3 && d[15:0] < 16'h0024) d[15:0] = 16'h0100;
         wr(a, d);
         rd(a, m[a]);
      end
      wr(6'h1, 24'h004);
      pw(1'b0, 7'h01);
      rd(6'h1, 24'hffffff);
      wr(6'h1, 24'h002);
      pw(1'b1, 7'h7f);
      ce_pin <= 1'b0;
      wr(6'h1, 24'h1fd);
      pw(1'b0, 7'h7f);
      ce_pin <= 1'b1;
      repeat (10) @(posedge clk);
      pw(1'b1, 7'h7f);
      wr(6'h1, 24'h201);
      repeat (40) @(posedge clk);
      chk("sleep", {pfd_tristate, sleep_active, chip_enable}, 3'b110);
      wr(6'h1, 24'h001);
      chk("wake", {pfd_tristate, sleep_active, chip_enable}, 3'b001);
      wr(6'h0, 24'h000001);
      chkall();
      tally_and_finish();
   end
endmodule
`default_nettype wire
